// *** logic/dspc_datapath.sv ***
// Operation
// [RQ1] ALU takes accumulator and product or scaler; result returns to it.
// [RQ2] Accumulator stores as separate high and low 16-bit halves.
// [RQ3] Stored value passes an output shift; accumulator stays unchanged.
// [RQ4] Branch target address is taken from the accumulator.
// [RQ5] Normalize operation on the accumulator value.
// [RQ6] Bit test of a data word sets a flag for branching.
// [RQ7] Scaler takes 16-bit data word, gives 32-bit ALU operand.
// [RQ8] Scaler left shift is zero through sixteen places.
// [RQ9] Low bits zero; high bits zero or sign per mode bit.
// [RQ10] Signed or unsigned 16x16 product in one cycle.
// [RQ11] Operand register holds one factor; product register holds result.
// [RQ12] Multiply-accumulate takes program and data bus words together.
// [RQ13] Four shift modes act on the product before the ALU.
// [RQ14] Product shift mode is a 2-bit code.
// [RQ15] Timer count decrements every machine cycle, ungated.
// [RQ16] Count reaching zero raises the timer interrupt.
// [RQ17] Next cycle reloads from period; interval is period plus one.
// [RQ18] 544 RAM words: 288 always data, 256 switchable.
// [RQ19] Two operations map the switchable block to data or program.
// [RQ20] On-chip and fast program memory run without wait states.
// [RQ21] Slow memory holds ready low; cycle waits until ready seen.
// [RQ22] Program, data and I/O spaces decoded; on-chip map follows config.
// [RQ23] Six control registers sit in data space as memory words; the code maps seven, adding the status word at 6.
// [RQ24] Timer register writes act next cycle; count reads show live value.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dspc_datapath (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rstn,
  // Instruction
  input  wire dspc_pkg::dspc_op_type i_op,
  input  wire logic [4:0]           i_shift,
  input  wire logic [3:0]           i_bit,
  input  wire logic [15:0]          i_data,
  input  wire logic [15:0]          i_pdata,
  // Data space port
  input  wire logic [15:0]          i_daddr,
  input  wire logic [15:0]          i_dwdata,
  input  wire logic                 i_dwr,
  input  wire logic                 i_drd,
  input  wire logic                 i_io,
  output logic      [15:0]          o_drdata,
  // Program space port
  input  wire logic [15:0]          i_paddr,
  input  wire logic [15:0]          i_pwdata,
  input  wire logic                 i_pwr,
  input  wire logic                 i_prd,
  output logic      [15:0]          o_prdata,
  // External memory
  input  wire logic                 i_ready,
  output logic                      o_ext_wait,
  // Results
  output logic      [31:0]          o_acc,
  output logic      [15:0]          o_store_data,
  output logic                      o_store_vld,
  output logic      [15:0]          o_branch_addr,
  output logic                      o_branch_vld,
  output logic                      o_bit_flag,
  output logic                      o_norm_done,
  output logic                      o_dual_blk_prog,
  output logic                      o_count_zero_irq
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] acc;
    logic [15:0] mul_opnd;
    logic [31:0] prod;
    logic        sign_ext;
    logic [1:0]  psh;
    logic        map_prog;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [15:0] mask;
    logic [7:0]  glob;
    logic [15:0] drdata;
    logic [15:0] prdata;
    logic [15:0] sdata;
    logic        svld;
    logic [15:0] baddr;
    logic        bvld;
    logic        tflag;
    logic        ndone;
    logic [1:0]  rdy_sy;
    logic        wait_st;
  } dspc_state_type;

  localparam dspc_state_type ST_RST = '{
    sign_ext: dspc_pkg::SIGN_RST, default: '0};

  dspc_state_type st_r;
  dspc_state_type st_nxt;

  logic [15:0] ram [dspc_pkg::RAM_WORDS];
  logic        ram_we;
  logic [9:0]  ram_widx;
  logic [15:0] ram_wdata;

  logic [31:0] scaled;
  logic [31:0] prod_sh;
  logic [31:0] acc_sh;
  logic [31:0] alu_b;
  logic [15:0] tmr_cnt;
  logic [15:0] tmr_per;
  logic        tmr_irq;
  logic        cnt_we;
  logic        per_we;
  logic        d_hit;
  logic        p_hit;
  logic [9:0]  d_idx;
  logic [9:0]  p_idx;
  logic        ready_s;
  logic [15:0] stat_word;

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  // [RQ7] scaler on data bus
  dspc_scaler #(
    .IN_W  (dspc_pkg::WORD_W),
    .OUT_W (dspc_pkg::ACC_W)
  ) u_scaler (
    .i_data     (i_data),
    .i_shift    (i_shift),
    .i_sign_ext (st_r.sign_ext),
    .o_data     (scaled)
  );

  dspc_timer #(
    .W (dspc_pkg::WORD_W)
  ) u_timer (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_cnt_we (cnt_we),
    .i_per_we (per_we),
    .i_wdata  (i_dwdata),
    .o_count  (tmr_cnt),
    .o_period (tmr_per),
    .o_irq    (tmr_irq)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  always_comb begin
    d_hit = 1'b1;
    d_idx = '0;
    p_hit = 1'b0;
    p_idx = '0;
    // [RQ22] data space on-chip map
    if (i_io) begin
      d_hit = 1'b0;
    end else if (i_daddr >= dspc_pkg::A_B2_LO &&
                 i_daddr <= dspc_pkg::A_B2_HI) begin
      d_idx = dspc_pkg::IDX_B2 + 10'(i_daddr - dspc_pkg::A_B2_LO);
    end else if (i_daddr >= dspc_pkg::A_B1_LO &&
                 i_daddr <= dspc_pkg::A_B1_HI) begin
      d_idx = dspc_pkg::IDX_B1 + 10'(i_daddr - dspc_pkg::A_B1_LO);
    end else if (!st_r.map_prog && i_daddr >= dspc_pkg::A_B0D_LO &&
                 i_daddr <= dspc_pkg::A_B0D_HI) begin
      d_idx = dspc_pkg::IDX_B0 + 10'(i_daddr - dspc_pkg::A_B0D_LO);
    end else if (i_daddr > dspc_pkg::A_STAT) begin
      d_hit = 1'b0;
    end
    // [RQ22] program space map
    if (st_r.map_prog && i_paddr >= dspc_pkg::A_B0P_LO) begin
      p_hit = 1'b1;
      p_idx = dspc_pkg::IDX_B0 + 10'(i_paddr - dspc_pkg::A_B0P_LO);
    end
  end

  // Timer count and period writes are decoded here so the timer sees them directly.
  // [RQ23] control registers in data space
  assign cnt_we = i_dwr && !i_io && i_daddr == dspc_pkg::A_CNT;
  assign per_we = i_dwr && !i_io && i_daddr == dspc_pkg::A_PER;

  assign ready_s = st_r.rdy_sy[1];
  assign stat_word = 16'({st_r.map_prog, st_r.psh, st_r.sign_ext});

  // ---------------------------------------------------------------
  // On-chip RAM
  // ---------------------------------------------------------------
  // [RQ18] three blocks in one array
  always_comb begin
    ram_we    = 1'b0;
    ram_widx  = d_idx;
    ram_wdata = i_dwdata;
    if (i_dwr && d_hit && i_daddr >= dspc_pkg::A_B2_LO) begin
      ram_we = 1'b1;
    end else if (i_pwr && p_hit) begin
      ram_we    = 1'b1;
      ram_widx  = p_idx;
      ram_wdata = i_pwdata;
    end
  end

  // The RAM holds no reset; software must load it before reading.
  always_ff @(posedge i_clk) begin
    if (ram_we) begin
      ram[ram_widx] <= ram_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Datapath
  // ---------------------------------------------------------------
  always_comb begin
    // [RQ13] product shift modes
    unique case (dspc_pkg::dspc_psh_type'(st_r.psh))
      dspc_pkg::PSH_NONE: prod_sh = st_r.prod;
      dspc_pkg::PSH_L1:   prod_sh = st_r.prod << dspc_pkg::PSH_L1_AMT;
      dspc_pkg::PSH_L4:   prod_sh = st_r.prod << dspc_pkg::PSH_L4_AMT;
      dspc_pkg::PSH_R6:
        prod_sh = 32'($signed(st_r.prod) >>> dspc_pkg::PSH_R6_AMT);
    endcase
    // [RQ1] second ALU input select
    alu_b = (i_op == dspc_pkg::OP_ADD_PROD || i_op == dspc_pkg::OP_MAC)
            ? prod_sh : scaled;
    // [RQ3] output shifter
    acc_sh = st_r.acc << i_shift[2:0];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.svld = 1'b0;
    st_nxt.bvld = 1'b0;
    // Only the second stage is read, so a metastable first stage is safe.
    st_nxt.rdy_sy = {st_r.rdy_sy[0], i_ready};

    unique case (i_op)
      dspc_pkg::OP_NOP: begin
      end
      // [RQ1] results return to accumulator
      dspc_pkg::OP_LOAD:     st_nxt.acc = alu_b;
      dspc_pkg::OP_ADD:      st_nxt.acc = st_r.acc + alu_b;
      dspc_pkg::OP_SUB:      st_nxt.acc = st_r.acc - alu_b;
      dspc_pkg::OP_ADD_PROD: st_nxt.acc = st_r.acc + alu_b;
      // [RQ11] operand register load
      dspc_pkg::OP_LOAD_OPND: st_nxt.mul_opnd = i_data;
      // [RQ10] signed or unsigned product
      dspc_pkg::OP_MUL_S:
        st_nxt.prod = 32'($signed(st_r.mul_opnd) * $signed(i_data));
      dspc_pkg::OP_MUL_U: st_nxt.prod = st_r.mul_opnd * i_data;
      // [RQ12] both buses feed multiplier
      dspc_pkg::OP_MAC: begin
        st_nxt.acc      = st_r.acc + alu_b;
        st_nxt.mul_opnd = i_pdata;
        st_nxt.prod     = 32'($signed(i_pdata) * $signed(i_data));
      end
      // [RQ2] high half store
      dspc_pkg::OP_STORE_HI: begin
        st_nxt.sdata = acc_sh[31:16];
        st_nxt.svld  = 1'b1;
      end
      // [RQ2] low half store
      dspc_pkg::OP_STORE_LO: begin
        st_nxt.sdata = acc_sh[15:0];
        st_nxt.svld  = 1'b1;
      end
      // [RQ4] branch to accumulator
      dspc_pkg::OP_BRANCH_ACC: begin
        st_nxt.baddr = st_r.acc[15:0];
        st_nxt.bvld  = 1'b1;
      end
      // [RQ5] one normalize step
      dspc_pkg::OP_NORM: begin
        if (st_r.acc != '0 && st_r.acc[31] == st_r.acc[30]) begin
          st_nxt.acc   = st_r.acc << 1;
          st_nxt.ndone = 1'b0;
        end else begin
          st_nxt.ndone = 1'b1;
        end
      end
      // [RQ6] bit test flag
      dspc_pkg::OP_BIT_TEST: st_nxt.tflag = i_data[i_bit];
      // [RQ19] block remap operations
      dspc_pkg::OP_MAP_DATA: st_nxt.map_prog = 1'b0;
      dspc_pkg::OP_MAP_PROG: st_nxt.map_prog = 1'b1;
    endcase

    // [RQ23] control register writes
    if (i_dwr && !i_io) begin
      unique case (i_daddr)
        dspc_pkg::A_RX:   st_nxt.rx = i_dwdata;
        dspc_pkg::A_TX:   st_nxt.tx = i_dwdata;
        dspc_pkg::A_MASK: st_nxt.mask = i_dwdata;
        dspc_pkg::A_GLOB: st_nxt.glob = i_dwdata[7:0];
        dspc_pkg::A_STAT: begin
          st_nxt.sign_ext = i_dwdata[dspc_pkg::ST_SIGN_BIT];
          // [RQ14] 2-bit product shift code
          st_nxt.psh = i_dwdata[dspc_pkg::ST_PSH_LSB +: 2];
        end
        default: begin
        end
      endcase
    end

    // [RQ24] live count on read
    if (i_drd) begin
      st_nxt.drdata = '0;
      if (i_io) begin
        st_nxt.drdata = '0;
      end else if (d_hit && i_daddr >= dspc_pkg::A_B2_LO) begin
        st_nxt.drdata = ram[d_idx];
      end else begin
        unique case (i_daddr)
          dspc_pkg::A_RX:   st_nxt.drdata = st_r.rx;
          dspc_pkg::A_TX:   st_nxt.drdata = st_r.tx;
          dspc_pkg::A_CNT:  st_nxt.drdata = tmr_cnt;
          dspc_pkg::A_PER:  st_nxt.drdata = tmr_per;
          dspc_pkg::A_MASK: st_nxt.drdata = st_r.mask;
          dspc_pkg::A_GLOB: st_nxt.drdata = 16'(st_r.glob);
          dspc_pkg::A_STAT: st_nxt.drdata = stat_word;
          default:          st_nxt.drdata = '0;
        endcase
      end
    end
    // [RQ20] on-chip program read, no wait
    if (i_prd) begin
      st_nxt.prdata = p_hit ? ram[p_idx] : '0;
    end

    // [RQ21] wait until ready seen
    if (st_r.wait_st) begin
      st_nxt.wait_st = !ready_s;
    end else if (((i_dwr || i_drd) && !d_hit) ||
                 ((i_prd || i_pwr) && !p_hit)) begin
      // [RQ20] fast memory holds ready high
      st_nxt.wait_st = !ready_s;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_drdata         = st_r.drdata;
  assign o_prdata         = st_r.prdata;
  assign o_ext_wait       = st_r.wait_st;
  assign o_acc            = st_r.acc;
  assign o_store_data     = st_r.sdata;
  assign o_store_vld      = st_r.svld;
  assign o_branch_addr    = st_r.baddr;
  assign o_branch_vld     = st_r.bvld;
  assign o_bit_flag       = st_r.tflag;
  assign o_norm_done      = st_r.ndone;
  assign o_dual_blk_prog  = st_r.map_prog;
  assign o_count_zero_irq = tmr_irq;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // [RQ3] accumulator kept on store
  a_store_keeps_acc: assert property (
    (i_op == dspc_pkg::OP_STORE_HI || i_op == dspc_pkg::OP_STORE_LO)
    |=> o_acc == $past(o_acc)) // [RQ3]
    else $error("Store changed the accumulator.");
  // [RQ2] high half value
  a_store_hi_val: assert property (
    (i_op == dspc_pkg::OP_STORE_HI && i_shift[2:0] == 3'h0)
    |=> o_store_vld && o_store_data == $past(o_acc[31:16])) // [RQ2]
    else $error("High half store value wrong.");
  // [RQ4] branch target
  a_branch_target: assert property (
    i_op == dspc_pkg::OP_BRANCH_ACC
    |=> o_branch_vld && o_branch_addr == $past(o_acc[15:0])) // [RQ4]
    else $error("Branch target not from accumulator.");
  // [RQ9] unsigned load
  a_load_no_sign: assert property (
    (i_op == dspc_pkg::OP_LOAD && i_shift == 5'h00 && !st_r.sign_ext)
    |=> o_acc == {16'h0000, $past(i_data)}) // [RQ9]
    else $error("Load without sign mode wrong.");
  // [RQ10] signed product
  a_mul_signed: assert property (
    i_op == dspc_pkg::OP_MUL_S
    |=> $signed(st_r.prod) ==
        $signed($past(st_r.mul_opnd)) * $signed($past(i_data))) // [RQ10]
    else $error("Signed product wrong.");
  // [RQ19] remap to program
  a_map_prog: assert property (
    i_op == dspc_pkg::OP_MAP_PROG ##1 i_op == dspc_pkg::OP_NOP
    |-> o_dual_blk_prog [*2]) // [RQ19]
    else $error("Block not mapped to program space.");
  // [RQ21] wait ends with ready
  a_wait_ready: assert property (
    o_ext_wait && ready_s |=> !o_ext_wait) // [RQ21]
    else $error("Wait held after ready.");
  // [RQ6] bit test
  a_bit_test: assert property (
    i_op == dspc_pkg::OP_BIT_TEST |=> o_bit_flag == $past(i_data[i_bit]))
    // [RQ6]
    else $error("Bit test flag wrong.");

  c_mac: cover property (i_op == dspc_pkg::OP_MAC ##1
                         i_op == dspc_pkg::OP_MAC);
  c_wait: cover property (o_ext_wait ##1 !o_ext_wait);
  c_branch: cover property (o_branch_vld);
endmodule : dspc_datapath
`default_nettype wire

// *** logic/dspc_pkg.sv ***
`default_nettype none
package dspc_pkg;
  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int ACC_W  = 32;
  localparam int IDX_W  = 10;
  localparam int GLB_W  = 8;
  localparam logic [4:0] SHIFT_MAX = 5'h10;

  // ---------------------------------------------------------------
  // Data-space control registers
  // ---------------------------------------------------------------
  localparam logic [15:0] A_RX   = 16'h0000;
  localparam logic [15:0] A_TX   = 16'h0001;
  localparam logic [15:0] A_CNT  = 16'h0002;
  localparam logic [15:0] A_PER  = 16'h0003;
  localparam logic [15:0] A_MASK = 16'h0004;
  localparam logic [15:0] A_GLOB = 16'h0005;
  localparam logic [15:0] A_STAT = 16'h0006;

  // ---------------------------------------------------------------
  // On-chip RAM map
  // ---------------------------------------------------------------
  localparam logic [15:0] A_B2_LO  = 16'h0060;
  localparam logic [15:0] A_B2_HI  = 16'h007f;
  localparam logic [15:0] A_B0D_LO = 16'h0200;
  localparam logic [15:0] A_B0D_HI = 16'h02ff;
  localparam logic [15:0] A_B1_LO  = 16'h0300;
  localparam logic [15:0] A_B1_HI  = 16'h03ff;
  localparam logic [15:0] A_B0P_LO = 16'hff00;
  localparam logic [15:0] A_B0P_HI = 16'hffff;
  localparam int          RAM_WORDS = 544;
  localparam logic [9:0]  IDX_B0 = 10'h000;
  localparam logic [9:0]  IDX_B1 = 10'h100;
  localparam logic [9:0]  IDX_B2 = 10'h200;

  // ---------------------------------------------------------------
  // Status word fields and reset values
  // ---------------------------------------------------------------
  localparam int         ST_SIGN_BIT = 0;
  localparam int         ST_PSH_LSB  = 1;
  localparam int         ST_MAP_BIT  = 3;
  localparam logic       SIGN_RST    = 1'b1;
  localparam logic [4:0] PSH_L1_AMT  = 5'h01;
  localparam logic [4:0] PSH_L4_AMT  = 5'h04;
  localparam logic [4:0] PSH_R6_AMT  = 5'h06;

  // ---------------------------------------------------------------
  // Operations and product shift codes
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP, OP_LOAD, OP_ADD, OP_SUB, OP_ADD_PROD, OP_LOAD_OPND,
    OP_MUL_S, OP_MUL_U, OP_MAC, OP_STORE_HI, OP_STORE_LO,
    OP_BRANCH_ACC, OP_NORM, OP_BIT_TEST, OP_MAP_DATA, OP_MAP_PROG
  } dspc_op_type;

  typedef enum logic [1:0] {
    PSH_NONE, PSH_L1, PSH_L4, PSH_R6
  } dspc_psh_type;
endpackage : dspc_pkg
`default_nettype wire

// *** logic/dspc_scaler.sv ***
`timescale 1ns/1ps
`default_nettype none
module dspc_scaler #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 32
) (
  // Operand
  input  wire logic [IN_W-1:0]  i_data,
  input  wire logic [4:0]       i_shift,
  input  wire logic             i_sign_ext,
  // Result
  output logic      [OUT_W-1:0] o_data
);
  generate
    if (OUT_W != 2 * IN_W) begin : g_chk
      $error("Scaler output must be twice the input width.");
    end
  endgenerate

  logic [OUT_W-1:0] ext;
  logic [4:0]       amt;

  always_comb begin
    // [RQ9] zero or sign fill
    ext = i_sign_ext ? {{IN_W{i_data[IN_W-1]}}, i_data}
                     : {{IN_W{1'b0}}, i_data};
    // [RQ8] shift range clamp
    amt = (i_shift > dspc_pkg::SHIFT_MAX) ? dspc_pkg::SHIFT_MAX : i_shift;
    // [RQ7] widen to ALU input
    o_data = ext << amt;
  end
endmodule : dspc_scaler
`default_nettype wire

// *** logic/dspc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dspc_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // Register writes
  input  wire logic         i_cnt_we,
  input  wire logic         i_per_we,
  input  wire logic [W-1:0] i_wdata,
  // State
  output logic      [W-1:0] o_count,
  output logic      [W-1:0] o_period,
  output logic              o_irq
);
  generate
    if (W < 2) begin : g_chk
      $error("Timer width too small.");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] per;
    logic         irq;
  } dspc_tmr_type;

  localparam dspc_tmr_type TMR_RST = '{cnt: '1, per: '1, irq: 1'b0};

  dspc_tmr_type st_r;
  dspc_tmr_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    // [RQ15] free-running decrement
    st_nxt.cnt = st_r.cnt - 1'b1;
    // [RQ17] reload after zero
    if (st_r.cnt == '0) begin
      st_nxt.cnt = st_r.per;
    end
    // [RQ16] zero raises interrupt
    st_nxt.irq = (st_r.cnt == '0);
    // [RQ24] writes land next cycle
    if (i_cnt_we) begin
      st_nxt.cnt = i_wdata;
    end
    if (i_per_we) begin
      st_nxt.per = i_wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= TMR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_count  = st_r.cnt;
  assign o_period = st_r.per;
  assign o_irq    = st_r.irq;

  // [RQ17] reload check
  a_tmr_reload: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_count == '0 && !i_cnt_we) |=> o_count == $past(o_period)) // [RQ17]
    else $error("Timer did not reload from period.");
  // [RQ16] interrupt check
  a_tmr_irq: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_irq == $past(o_count == '0)) // [RQ16]
    else $error("Timer interrupt not tied to zero count.");
  c_tmr_irq: cover property (@(posedge i_clk) disable iff (!i_rstn) o_irq);
endmodule : dspc_timer
`default_nettype wire

// *** tb/dspc_datapath_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module dspc_datapath_tb;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_dwr = 1'b0, i_drd = 1'b0;
  logic i_io = 1'b0, i_pwr = 1'b0, i_prd = 1'b0, i_ready;
  dspc_pkg::dspc_op_type i_op = dspc_pkg::OP_NOP;
  logic [4:0] i_shift = 5'h00;
  logic [3:0] i_bit = 4'h0, dly = 4'h0;
  logic [15:0] i_data = 16'h0000, i_pdata = 16'h0000, i_daddr = 16'h0000;
  logic [15:0] i_dwdata = 16'h0000, i_paddr = 16'h0000, i_pwdata = 16'h0000;
  logic [15:0] o_drdata, o_prdata, o_store_data, o_branch_addr;
  logic [31:0] o_acc;
  logic o_ext_wait, o_store_vld, o_branch_vld, o_bit_flag, o_norm_done;
  logic o_dual_blk_prog, o_count_zero_irq;
  int err_count = 0, n_checks = 0, n;
  always #50 i_clk = ~i_clk;
  dspc_mem_model i_mem (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_req(i_drd | i_prd), .i_delay(dly), .o_ready(i_ready));
  dspc_datapath i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_op(i_op),
    .i_shift(i_shift), .i_bit(i_bit), .i_data(i_data), .i_pdata(i_pdata),
    .i_daddr(i_daddr), .i_dwdata(i_dwdata), .i_dwr(i_dwr), .i_drd(i_drd),
    .i_io(i_io), .o_drdata(o_drdata), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pwr(i_pwr), .i_prd(i_prd), .o_prdata(o_prdata),
    .i_ready(i_ready), .o_ext_wait(o_ext_wait), .o_acc(o_acc),
    .o_store_data(o_store_data), .o_store_vld(o_store_vld),
    .o_branch_addr(o_branch_addr), .o_branch_vld(o_branch_vld),
    .o_bit_flag(o_bit_flag), .o_norm_done(o_norm_done),
    .o_dual_blk_prog(o_dual_blk_prog), .o_count_zero_irq(o_count_zero_irq));
  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task op(input dspc_pkg::dspc_op_type o, input logic [15:0] d,
          input logic [4:0] s, input logic [15:0] pd);
    @(posedge i_clk);
    i_op <= o; i_data <= d; i_shift <= s; i_bit <= s[3:0]; i_pdata <= pd;
  endtask : op
  task done;
    op(dspc_pkg::OP_NOP, 16'h0000, 5'h00, 16'h0000);
    #1;
  endtask : done
  task wr(input bit p, input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    if (p) begin i_pwr <= 1'b1; i_paddr <= a; i_pwdata <= d; end
    else begin i_dwr <= 1'b1; i_daddr <= a; i_dwdata <= d; end
    @(posedge i_clk);
    i_pwr <= 1'b0; i_dwr <= 1'b0;
  endtask : wr
  task rd(input bit p, input logic [15:0] a, input logic [15:0] e);
    @(posedge i_clk);
    if (p) begin i_prd <= 1'b1; i_paddr <= a; end
    else begin i_drd <= 1'b1; i_daddr <= a; end
    @(posedge i_clk);
    i_prd <= 1'b0; i_drd <= 1'b0;
    #1 chk(p ? o_prdata : o_drdata, {16'h0000, e});
  endtask : rd
  task ext(input logic [3:0] dl, input logic e);
    logic s;
    s = 1'b0;
    @(posedge i_clk);
    dly <= dl;
    repeat (2) @(posedge i_clk);
    i_io <= 1'b1; i_drd <= 1'b1; i_daddr <= dspc_pkg::A_GLOB;
    @(posedge i_clk);
    i_drd <= 1'b0;
    for (int k = 0; k < 16; k++) begin @(posedge i_clk); #1 s |= o_ext_wait; end
    @(posedge i_clk);
    i_io <= 1'b0; dly <= 4'h0;
    #1 chk({31'h0, s}, {31'h0, e});
    chk({31'h0, o_ext_wait}, 32'h0);
  endtask : ext
  task results;
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #200000;
    err_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(0, dspc_pkg::A_STAT, 16'h0001);
    wr(0, 16'h0300, 16'ha5c3); rd(0, 16'h0300, 16'ha5c3);
    op(dspc_pkg::OP_LOAD, 16'h8001, 5'h04, 0); done; chk(o_acc, 32'hfff80010);
    op(dspc_pkg::OP_LOAD, 16'h8001, 5'h10, 0); done; chk(o_acc, 32'h80010000);
    op(dspc_pkg::OP_LOAD, 16'h8001, 5'h00, 0); done; chk(o_acc, 32'hffff8001);
    op(dspc_pkg::OP_LOAD, 16'h7fff, 5'h11, 0); done; chk(o_acc, 32'h7fff0000);
    wr(0, dspc_pkg::A_STAT, 16'h0000);
    op(dspc_pkg::OP_LOAD, 16'h8001, 5'h04, 0); done; chk(o_acc, 32'h00080010);
    op(dspc_pkg::OP_MAC, 16'hfffe, 5'h00, 16'h0003);
    for (int m = 0; m < 4; m++) begin
      wr(0, dspc_pkg::A_STAT, {13'h0, m[1:0], 1'b1});
      op(dspc_pkg::OP_LOAD, 16'h0000, 5'h00, 0);
      op(dspc_pkg::OP_ADD_PROD, 16'h0000, 5'h00, 0); done;
      chk(o_acc, m == 0 ? 32'hfffffffa : m == 1 ? 32'hfffffff4 :
          m == 2 ? 32'hffffffa0 : 32'hffffffff);
    end
    op(dspc_pkg::OP_LOAD, 16'h1234, 5'h10, 0);
    op(dspc_pkg::OP_ADD, 16'h5678, 5'h00, 0);
    op(dspc_pkg::OP_STORE_HI, 0, 0, 0);
    op(dspc_pkg::OP_STORE_LO, 0, 5'h04, 0); #1 chk(o_acc, 32'h12345678);
    chk({o_store_vld, o_store_data}, 17'h11234);
    op(dspc_pkg::OP_BRANCH_ACC, 0, 0, 0); #1;
    chk({o_store_vld, o_store_data}, 17'h16780);
    done; chk({o_branch_vld, o_branch_addr}, 17'h15678);
    chk(o_acc, 32'h12345678);
    op(dspc_pkg::OP_BIT_TEST, 16'h0020, 5'h05, 0); done; chk(o_bit_flag, 1);
    op(dspc_pkg::OP_BIT_TEST, 16'h0020, 5'h04, 0); done; chk(o_bit_flag, 0);
    op(dspc_pkg::OP_LOAD, 16'h2000, 5'h10, 0);
    op(dspc_pkg::OP_NORM, 0, 0, 0); done; chk(o_acc, 32'h40000000);
    chk(o_norm_done, 0);
    op(dspc_pkg::OP_NORM, 0, 0, 0); done; chk(o_norm_done, 1);
    chk(o_acc, 32'h40000000);
    wr(0, dspc_pkg::A_STAT, 16'h0000);
    op(dspc_pkg::OP_LOAD_OPND, 16'hfffe, 0, 0);
    op(dspc_pkg::OP_MUL_U, 16'h0003, 0, 0);
    op(dspc_pkg::OP_LOAD, 0, 0, 0);
    op(dspc_pkg::OP_ADD_PROD, 0, 0, 0); done;
    chk(o_acc, 32'h0002fffa);
    op(dspc_pkg::OP_MUL_S, 16'h0003, 0, 0);
    op(dspc_pkg::OP_LOAD, 0, 0, 0);
    op(dspc_pkg::OP_ADD_PROD, 0, 0, 0);
    op(dspc_pkg::OP_SUB, 16'h0006, 0, 0); done;
    chk(o_acc, 32'hfffffff4);
    op(dspc_pkg::OP_MAP_PROG, 0, 0, 0); done; chk(o_dual_blk_prog, 1);
    wr(1, 16'hff10, 16'hbeef); rd(1, 16'hff10, 16'hbeef);
    op(dspc_pkg::OP_MAP_DATA, 0, 0, 0); done; chk(o_dual_blk_prog, 0);
    rd(0, 16'h0210, 16'hbeef);
    wr(0, dspc_pkg::A_PER, 16'h0004); wr(0, dspc_pkg::A_CNT, 16'h0002);
    n = 0;
    while (o_count_zero_irq !== 1'b1 && n < 20) begin @(posedge i_clk); #1 n++; end
    chk(n, 3);
    n = 0;
    do begin @(posedge i_clk); #1 n++; end while (o_count_zero_irq !== 1'b1 && n < 20);
    chk(n, 5);
    rd(0, dspc_pkg::A_CNT, 16'h0003);
    ext(4'h0, 1'b0);
    ext(4'h6, 1'b1);
    results();
  end
endmodule : dspc_datapath_tb
`default_nettype wire

// *** tb/dspc_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module dspc_mem_model (
  // Bus side
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_req,
  input  wire logic [3:0] i_delay,
  // Ready pin
  output logic            o_ready
);
  logic [3:0] cnt_r;
  logic       done_r;
  // ready held low
  // A slow device pulls ready low as soon as it is set up, so the
  // synchronised level is already low when the access is taken.
  // Fast memory keeps ready high and never causes a stall.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (i_delay == 4'h0) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b0;
    end else if (i_req) begin
      cnt_r <= i_delay;
    end else if (cnt_r == 4'h1) begin
      cnt_r  <= 4'h0;
      done_r <= 1'b1;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign o_ready = (i_delay == 4'h0) || done_r;
endmodule : dspc_mem_model
`default_nettype wire
